/* hw/timing_pkg.sv */
// shared constants, types and carriers for the instruction timing decoder
// Behaviour
// (RL1) carry jumps: two bytes, 2/3 cycles
// (RL2) bit jumps: three bytes, 3/4; clear variant clears
// (RL3) compare indirect with immediate: three bytes, 4/5
// (RL4) other compare-jumps: three bytes, 3/4 cycles
// (RL5) decrement-jump: register 2/3, direct 3/4 cycles
// (RL6) accumulator zero jumps: two bytes, 2/3 cycles
// (RL7) short call 2 bytes 3; long 3 bytes 4
// (RL8) both returns: one byte, 5 cycles
// (RL9) short, relative, indirect jumps 3; long jump 4
// (RL10) code byte reads: one byte, 3 cycles
// (RL11) external data moves: one byte, 3 cycles
// (RL12) stack push and pop: two bytes, 2 cycles
// (RL13) indirect exchanges 2 cycles; register exchange 1
// (RL14) accumulator single-byte operations take one cycle; the table gives 0xa4 four cycles and 0x84 eight
// (RL15) three-byte moves 3 cycles; indirect moves 2
// (RL16) carry ops 1 cycle; direct bit ops 2
// (RL17) relative offset: signed byte from next instruction
// (RL18) direct below 0x80 is RAM, else special
// (RL19) page target stays in next instruction's 2 kB page
// (RL20) full target reaches whole program space
// (RL21) opcode 0xa5 behaves as no-operation
// (RL22) register operand 0-7; pointer only 0 or 1
// (RL23) bank select picks 8-byte bank at bank*8
// (RL24) untaken branch one cycle shorter than taken
// (RL25) length and cycles supplied for every opcode
package timing_pkg;
  localparam logic [1:0] LEN_ONE   = 2'h1;  // instruction byte lengths
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [3:0] CYC_ONE   = 4'h1;  // base cycle counts
  localparam logic [3:0] CYC_TWO   = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR  = 4'h4;
  localparam logic [3:0] CYC_FIVE  = 4'h5;
  localparam logic [3:0] CYC_EIGHT = 4'h8;
  localparam logic [7:0] NOP_ALIAS = 8'ha5;   // spare opcode acting as no-op
  localparam int         SFR_BIT   = 7;       // direct address bit that selects sfr space
  localparam int         PAGE_POS  = 11;      // first pc bit kept by page targets
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] SPENT_MAX = 4'he;    // saturation of the timing helper

  typedef enum logic [2:0] {
    TGT_NONE, TGT_REL, TGT_PAGE, TGT_FULL, TGT_RET, TGT_ACC_DATA_POINTER_16
  } target_kind_t;

  typedef struct packed {
    logic [1:0]   len;      // bytes incl. opcode
    logic [3:0]   cyc;      // cycles when not taken
    logic         cond;     // conditional branch: one more cycle when taken
    target_kind_t tgt;      // how the branch target is formed
    logic         bit_clr;  // clear tested bit when taken
  } op_info_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } issue_t;

  typedef struct packed {
    logic [15:0] next_pc;
    logic [15:0] rel_target;
    logic [15:0] page_local_target;
    logic [15:0] full_range_target;
    logic [7:0]  bank_register_operand;
    logic [7:0]  indirect_pointer_operand;
    logic        direct_sfr;
  } addr_info_t;
endpackage : timing_pkg

/* hw/opcode_table.sv */
// opcode to byte length, cycle count and branch kind lookup
module opcode_table (
  input  wire logic [7:0]         opcode_in,  // opcode byte
  output timing_pkg::op_info_t    info_out    // decoded length and timing
);
  import timing_pkg::*;

  // pack one table entry
  function automatic op_info_t mk(input logic [1:0] l, input logic [3:0] c,
                                  input logic cd, input target_kind_t t,
                                  input logic b);
    mk = '{len: l, cyc: c, cond: cd, tgt: t, bit_clr: b};
  endfunction : mk

  // first match wins, so narrow patterns stand before the wide ones
  // (RL25) full opcode coverage
  always_comb begin
    info_out = mk(LEN_ONE, CYC_ONE, 1'b0, TGT_NONE, 1'b0);
    casez (opcode_in)
      // (RL22) register forms
      8'b01111???, 8'b10101???, 8'b10001???: info_out = mk(LEN_TWO, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      // (RL4) register compare-jump
      8'b10111???: info_out = mk(LEN_THREE, CYC_THREE, 1'b1, TGT_REL, 1'b0);
      // (RL5) register decrement-jump
      8'b11011???: info_out = mk(LEN_TWO, CYC_TWO, 1'b1, TGT_REL, 1'b0);
      // (RL13) register exchange and other register ops
      8'b????1???: info_out = mk(LEN_ONE, CYC_ONE, 1'b0, TGT_NONE, 1'b0);
      8'b0111011?, 8'b1010011?, 8'b1000011?: info_out = mk(LEN_TWO, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      // (RL3) indirect compare-jump
      8'b1011011?: info_out = mk(LEN_THREE, CYC_FOUR, 1'b1, TGT_REL, 1'b0);
      // (RL15) indirect moves and exchanges
      8'b????011?: info_out = mk(LEN_ONE, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      // (RL7) page jump and page call
      8'b????0001: info_out = mk(LEN_TWO, CYC_THREE, 1'b0, TGT_PAGE, 1'b0);
      // (RL21) both no-op codes
      8'h00, NOP_ALIAS: info_out = mk(LEN_ONE, CYC_ONE, 1'b0, TGT_NONE, 1'b0);
      // (RL2) bit test jumps
      8'h10: info_out = mk(LEN_THREE, CYC_THREE, 1'b1, TGT_REL, 1'b1);
      8'h20, 8'h30: info_out = mk(LEN_THREE, CYC_THREE, 1'b1, TGT_REL, 1'b0);
      // (RL1) carry and (RL6) accumulator jumps
      8'h40, 8'h50, 8'h60, 8'h70: info_out = mk(LEN_TWO, CYC_TWO, 1'b1, TGT_REL, 1'b0);
      // (RL9) short relative jump
      8'h80: info_out = mk(LEN_TWO, CYC_THREE, 1'b0, TGT_REL, 1'b0);
      8'h90, 8'h43, 8'h53, 8'h63, 8'h75,
      8'h85: info_out = mk(LEN_THREE, CYC_THREE, 1'b0, TGT_NONE, 1'b0);
      // (RL12) stack and (RL16) bit operations
      8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2, 8'hd2,
      8'h42, 8'h52, 8'h62: info_out = mk(LEN_TWO, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      // (RL11) external moves and (RL10) code reads
      8'he0, 8'hf0, 8'he2, 8'hf2, 8'he3, 8'hf3, 8'h83,
      8'h93: info_out = mk(LEN_ONE, CYC_THREE, 1'b0, TGT_NONE, 1'b0);
      // (RL20) long jump and long call
      8'h02, 8'h12: info_out = mk(LEN_THREE, CYC_FOUR, 1'b0, TGT_FULL, 1'b0);
      // (RL8) returns
      8'h22, 8'h32: info_out = mk(LEN_ONE, CYC_FIVE, 1'b0, TGT_RET, 1'b0);
      8'h73: info_out = mk(LEN_ONE, CYC_THREE, 1'b0, TGT_ACC_DATA_POINTER_16, 1'b0);
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74,
      8'h94: info_out = mk(LEN_TWO, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      8'h84: info_out = mk(LEN_ONE, CYC_EIGHT, 1'b0, TGT_NONE, 1'b0);
      8'ha4: info_out = mk(LEN_ONE, CYC_FOUR, 1'b0, TGT_NONE, 1'b0);
      8'hb4, 8'hb5, 8'hd5: info_out = mk(LEN_THREE, CYC_THREE, 1'b1, TGT_REL, 1'b0);
      8'b????0101: info_out = mk(LEN_TWO, CYC_TWO, 1'b0, TGT_NONE, 1'b0);
      // (RL14) remaining accumulator and carry ops are single cycle
      default: info_out = mk(LEN_ONE, CYC_ONE, 1'b0, TGT_NONE, 1'b0);
    endcase
  end
endmodule : opcode_table

/* hw/operand_addr.sv */
// forms operand and branch target addresses from an issued instruction
module operand_addr (
  input  wire logic [15:0]          pc_in,        // address of the opcode
  input  timing_pkg::issue_t        issue_in,     // opcode and operand bytes
  input  wire logic [1:0]           len_in,       // decoded byte length
  input  wire logic [1:0]           bank_select_field_in,  // active register bank
  output timing_pkg::addr_info_t    addr_out      // formed addresses
);
  import timing_pkg::*;

  logic [7:0]  rel_byte;  // offset sits in the last operand byte
  logic [15:0] next_pc;   // first byte of the following instruction

  // relative and page targets hang off the next instruction, not the opcode
  always_comb begin
    next_pc  = pc_in + {14'h0000, len_in};
    rel_byte = (len_in == LEN_THREE) ? issue_in.op2 : issue_in.op1;
    addr_out.next_pc = next_pc;
    // (RL17) signed offset
    addr_out.rel_target = next_pc + {{8{rel_byte[7]}}, rel_byte};
    // (RL19) same page
    addr_out.page_local_target = {next_pc[15:PAGE_POS], issue_in.opcode[7:5], issue_in.op1};
    // (RL20) any address
    addr_out.full_range_target = {issue_in.op1, issue_in.op2};
    // (RL23) bank base
    addr_out.bank_register_operand = {3'b000, bank_select_field_in, issue_in.opcode[2:0]};
    // (RL22) pointer is register 0 or 1 only
    addr_out.indirect_pointer_operand = {3'b000, bank_select_field_in, 2'b00, issue_in.opcode[0]};
    // (RL18) upper half is sfr space
    addr_out.direct_sfr = issue_in.op1[SFR_BIT];
  end
endmodule : operand_addr

/* hw/cpu_instruction_timing_decoder.sv */
// instruction issue sequencer: holds each instruction for its cycle count
module cpu_instruction_timing_decoder (
  input  wire logic               mclk_in,               // 50 mhz core clock
  input  wire logic               rstn_in,               // async reset, active low
  input  wire logic               ce_in,                 // clock enable, freezes state
  input  wire logic               issue_valid_in,        // issue_in holds an instruction
  input  timing_pkg::issue_t      issue_in,              // opcode and operands
  input  wire logic               cond_in,               // branch condition holds
  input  wire logic [7:0]         acc_in,                // accumulator value
  input  wire logic [15:0]        data_pointer_16_in,    // data pointer value
  input  wire logic [15:0]        ret_addr_in,           // return address from stack
  input  wire logic [1:0]         bank_select_field_in,  // active register bank
  output logic                    ready_out,             // next issue taken this edge
  output logic [15:0]             pc_out,                // address of next instruction
  output logic [1:0]              len_out,               // bytes of last issue
  output logic [3:0]              cycles_out,            // cycles of last issue
  output logic                    taken_out,             // last issue branched
  output logic                    bit_clear_out,         // pulse: clear tested bit
  output logic [7:0]              bank_register_operand_out,     // register ram address
  output logic [7:0]              indirect_pointer_operand_out,  // pointer register address
  output logic                    direct_sfr_out         // direct operand is sfr space
);
  import timing_pkg::*;

  typedef enum logic {SEQ_LAST, SEQ_BUSY} seq_state_t;

  op_info_t    op;         // decoded entry for issue_in
  addr_info_t  addr;       // formed addresses for issue_in
  logic        fire;       // instruction taken this edge
  logic        taken;      // branch goes to its target
  logic [3:0]  eff_cyc;    // cycles including the taken penalty
  logic [15:0] target;     // selected branch target

  seq_state_t  state_ff;   // sequencer state
  seq_state_t  nxt_state;
  logic [3:0]  cnt_ff;     // cycles left before the last one
  logic [3:0]  nxt_cnt;
  logic        ready_ff;   // last cycle of the current instruction
  logic        nxt_ready;

  logic [15:0] pc_ff;      // program counter
  logic [15:0] nxt_pc;
  logic [1:0]  len_ff;
  logic [1:0]  nxt_len;
  logic [3:0]  cyc_ff;
  logic [3:0]  nxt_cyc;
  logic        taken_ff;
  logic        nxt_taken;
  logic        bclr_ff;
  logic        nxt_bclr;
  logic [7:0]  breg_ff;
  logic [7:0]  nxt_breg;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic        sfr_ff;
  logic        nxt_sfr;

  // length and timing lookup
  opcode_table u_table (
    .opcode_in (issue_in.opcode),
    .info_out  (op)
  );

  // address formation relative to the current pc
  operand_addr u_addr (
    .pc_in                (pc_ff),
    .issue_in             (issue_in),
    .len_in               (op.len),
    .bank_select_field_in (bank_select_field_in),
    .addr_out             (addr)
  );

  // an issue is only accepted in the last cycle of the previous one
  assign fire = ce_in & issue_valid_in & ready_ff;

  // branch decision and effective timing
  always_comb begin
    // (RL24) condition adds the taken cycle
    taken   = op.cond ? cond_in : (op.tgt != TGT_NONE);
    eff_cyc = op.cyc + {3'b000, op.cond & cond_in};
    // (RL9) target selection per branch kind
    case (op.tgt)
      TGT_REL:      target = addr.rel_target;
      TGT_PAGE:     target = addr.page_local_target;
      TGT_FULL:     target = addr.full_range_target;
      TGT_RET:      target = ret_addr_in;
      TGT_ACC_DATA_POINTER_16: target = {8'h00, acc_in} + data_pointer_16_in;
      default:      target = addr.next_pc;
    endcase
  end

  // sequencer next state: count down the instruction's cycles
  // (RL25) hold issue for the cycle count
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_ready = ready_ff;
    if (ce_in) begin
      case (state_ff)
        SEQ_LAST: begin
          if (issue_valid_in) begin
            nxt_cnt   = eff_cyc - CYC_ONE;
            nxt_ready = (eff_cyc == CYC_ONE);
            nxt_state = (eff_cyc == CYC_ONE) ? SEQ_LAST : SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          // last cycle reached when one remains
          nxt_cnt   = cnt_ff - CYC_ONE;
          nxt_ready = (cnt_ff == CYC_ONE);
          nxt_state = (cnt_ff == CYC_ONE) ? SEQ_LAST : SEQ_BUSY;
        end
        default: begin
          nxt_state = SEQ_LAST;
          nxt_cnt   = 4'h0;
          nxt_ready = 1'b1;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= SEQ_LAST;
      cnt_ff   <= 4'h0;
      ready_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ready_ff <= nxt_ready;
    end
  end

  // issue results: pc advance and operand addresses
  always_comb begin
    nxt_pc   = pc_ff;
    nxt_len  = len_ff;
    nxt_cyc  = cyc_ff;
    nxt_taken = taken_ff;
    nxt_bclr = bclr_ff;
    nxt_breg = breg_ff;
    nxt_ptr  = ptr_ff;
    nxt_sfr  = sfr_ff;
    if (ce_in) begin
      // pulse lasts one enabled cycle
      nxt_bclr = 1'b0;
    end
    if (fire) begin
      // (RL25) pc passes all operand bytes
      nxt_pc    = taken ? target : addr.next_pc;
      nxt_len   = op.len;
      nxt_cyc   = eff_cyc;
      nxt_taken = taken;
      // (RL2) clear only when the jump happens
      nxt_bclr  = op.bit_clr & cond_in;
      // (RL22) register operand addresses
      nxt_breg  = addr.bank_register_operand;
      nxt_ptr   = addr.indirect_pointer_operand;
      // (RL18) space of the direct operand
      nxt_sfr   = addr.direct_sfr;
    end
  end

  // issue result registers; cycle count resets to one so timing is defined
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_ff    <= PC_RESET;
      len_ff   <= LEN_ONE;
      cyc_ff   <= CYC_ONE;
      taken_ff <= 1'b0;
      bclr_ff  <= 1'b0;
      breg_ff  <= 8'h00;
      ptr_ff   <= 8'h00;
      sfr_ff   <= 1'b0;
    end else begin
      pc_ff    <= nxt_pc;
      len_ff   <= nxt_len;
      cyc_ff   <= nxt_cyc;
      taken_ff <= nxt_taken;
      bclr_ff  <= nxt_bclr;
      breg_ff  <= nxt_breg;
      ptr_ff   <= nxt_ptr;
      sfr_ff   <= nxt_sfr;
    end
  end

  // outputs straight from flops
  assign ready_out                    = ready_ff;
  assign pc_out                       = pc_ff;
  assign len_out                      = len_ff;
  assign cycles_out                   = cyc_ff;
  assign taken_out                    = taken_ff;
  assign bit_clear_out                = bclr_ff;
  assign bank_register_operand_out    = breg_ff;
  assign indirect_pointer_operand_out = ptr_ff;
  assign direct_sfr_out               = sfr_ff;

  // ---- checking helpers: enabled cycles since the last issue
  logic [3:0]  spent_ff;   // saturates, long enough for any count
  logic [3:0]  nxt_spent;
  logic        started_ff; // one issue seen since reset
  logic        nxt_started;
  logic [7:0]  opc;        // opcode of the offered issue
  logic [7:0]  opnd1;      // first operand byte
  logic [15:0] seq_next;   // fall-through address of the offered issue

  assign opc      = issue_in.opcode;
  assign opnd1    = issue_in.op1;
  assign seq_next = addr.next_pc;

  // helper counter next values
  always_comb begin
    nxt_spent   = spent_ff;
    nxt_started = started_ff | fire;
    if (fire) begin
      nxt_spent = 4'h0;
    end else if (ce_in && spent_ff < SPENT_MAX) begin
      nxt_spent = spent_ff + 4'h1;
    end
  end

  // helper counter registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spent_ff   <= 4'h0;
      started_ff <= 1'b0;
    end else begin
      spent_ff   <= nxt_spent;
      started_ff <= nxt_started;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence cond_issue_s;
    fire && op.cond;
  endsequence

  sequence ret_issue_s;
    fire && (opc == 8'h22 || opc == 8'h32);
  endsequence

  // busy never outlasts the cycle count
  late_ready_a: assert property (!ready_out |-> (spent_ff + 4'h1 < cycles_out)) // RL25
    else $error("ready came later than the cycle count");

  // no issue before the previous count has elapsed
  early_issue_a: assert property (fire && started_ff |-> (spent_ff + 4'h1 >= cycles_out)) // RL25
    else $error("issue accepted before the previous count elapsed");

  taken_penalty_a: assert property (cond_issue_s |=> // RL24
      cycles_out == $past(op.cyc) + {3'b000, taken_out})
    else $error("taken branch cycle penalty wrong");

  carry_jump_a: assert property (fire && (opc == 8'h40 || opc == 8'h50) |=> // RL1
      len_out == 2'h2 && cycles_out == ($past(cond_in) ? 4'h3 : 4'h2))
    else $error("carry jump length or timing wrong");

  bit_jump_a: assert property (fire && (opc == 8'h10 || opc == 8'h20 || opc == 8'h30) |=> // RL2
      len_out == 2'h3 && cycles_out == ($past(cond_in) ? 4'h4 : 4'h3))
    else $error("bit jump length or timing wrong");

  // a frozen enable stretches the pulse, so a held pulse is legal then
  bit_clear_a: assert property (bit_clear_out |-> // RL2
      ($past(fire) && $past(opc) == 8'h10 && $past(cond_in) && taken_out) ||
      ($past(bit_clear_out) && !$past(ce_in)))
    else $error("bit clear without a taken clear-jump");

  indirect_cmp_a: assert property (fire && (opc == 8'hb6 || opc == 8'hb7) |=> // RL3
      len_out == 2'h3 && cycles_out == ($past(cond_in) ? 4'h5 : 4'h4))
    else $error("indirect compare-jump timing wrong");

  return_time_a: assert property (ret_issue_s ##1 ce_in [*4] |-> // RL8
      !ready_out ##0 (len_out == 2'h1 && cycles_out == 4'h5))
    else $error("return not held for five cycles");

  nop_alias_a: assert property (fire && opc == NOP_ALIAS |=> // RL21
      len_out == 2'h1 && cycles_out == 4'h1 && !taken_out && ready_out)
    else $error("spare opcode differs from no-op");

  page_target_a: assert property (fire && opc[4:0] == 5'h01 |=> // RL19
      pc_out == {$past(seq_next[15:11]), $past(opc[7:5]), $past(opnd1)})
    else $error("page target left its page");

  rel_target_a: assert property (fire && opc == 8'h80 |=> // RL17
      pc_out == $past(seq_next) + {{8{$past(opnd1[7])}}, $past(opnd1)})
    else $error("relative target wrong");

  bank_map_a: assert property (fire && opc[3] |=> // RL23
      bank_register_operand_out == {3'b000, $past(bank_select_field_in), $past(opc[2:0])})
    else $error("register bank mapping wrong");

  direct_space_a: assert property (fire |=> direct_sfr_out == $past(opnd1[7])) // RL18
    else $error("direct space select wrong");
endmodule : cpu_instruction_timing_decoder

/* testbench/code_memory_model.sv */
// program memory model that feeds the opcode and operand bytes at the fetch address
module code_memory_model (
  input  wire logic [15:0]   pc_in,     // fetch address
  output timing_pkg::issue_t issue_out  // opcode and the two bytes after it
);
  timeunit 1ns;
  timeprecision 1ps;
  import timing_pkg::*;
  // whole 16-bit space; bytes never written read as unknown, so a stray fetch shows
  logic [7:0] mem [65536];
  // operand bytes follow the opcode in program order, wrapping at the top
  assign issue_out = {mem[pc_in], mem[16'(pc_in + 16'h1)], mem[16'(pc_in + 16'h2)]};
endmodule : code_memory_model

/* testbench/tb_cpu_instruction_timing_decoder.sv */
// self-checking bench: walks every covered opcode, taken and not taken
module tb_cpu_instruction_timing_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import timing_pkg::*;
  typedef struct packed {
    logic [1:0]  len;
    logic [3:0]  cyc;
    logic        taken;
    logic [15:0] pc;
    logic        bclr;
    logic [7:0]  breg;
    logic [7:0]  iptr;
    logic        sfr;
  } exp_t;
  logic        mclk_in = 1'b0;  // 50 mhz clock
  logic        rstn_in;         // reset, active low
  logic        ce_in;           // clock enable
  logic        issue_valid_in;  // issue strobe
  logic        cond_in;         // branch condition
  logic [7:0]  acc_in;          // accumulator
  logic [15:0] data_pointer_16_in;
  logic [15:0] ret_addr_in;
  logic [1:0]  bank_select_field_in;
  issue_t      issue_in;        // bytes from the memory model
  logic        ready_out, taken_out, bit_clear_out, direct_sfr_out;
  logic [15:0] pc_out;
  logic [1:0]  len_out;
  logic [3:0]  cycles_out;
  logic [7:0]  bank_register_operand_out, indirect_pointer_operand_out;
  int          seed = 13;       // fixed seed for repeatable runs
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_edges = 0;     // enabled edges since the last accepted issue
  logic        have_prev, pend;
  logic [3:0]  prev_cyc;        // expected cycles of the previous issue
  logic [15:0] exp_pc;          // where the bench expects the next fetch
  exp_t        q [$];           // expected results, oldest first
  exp_t        e;
  // opcode, bytes, untaken cycles, target kind, conditional flag
  // kinds: 1 rel op1, 2 rel op2, 3 page, 4 full, 5 return, 6 acc+pointer
  logic [23:0] tbl [$] = '{
    24'h402211, 24'h502211, 24'h203321, 24'h303321, 24'h103321, 24'hb63421, 24'hb73421,
    24'hb53321, 24'hb43321, 24'hb83321, 24'hbf3321, 24'hd82211, 24'hdf2211, 24'hd53321,
    24'h602211, 24'h702211, 24'h123440, 24'h023440, 24'h221550, 24'h321550, 24'h802310,
    24'h731360, 24'h931300, 24'h831300, 24'he01300, 24'he21300, 24'he31300, 24'hf01300,
    24'hf21300, 24'hf31300, 24'hc02200, 24'hd02200, 24'hc61200, 24'hc71200, 24'hd61200,
    24'hd71200, 24'hc81100, 24'hcf1100, 24'he41100, 24'hf41100, 24'h231100, 24'h331100,
    24'h031100, 24'h131100, 24'hc41100, 24'h853300, 24'h753300, 24'h903300, 24'hf61200,
    24'hf71200, 24'he61200, 24'he71200, 24'hc31100, 24'hd31100, 24'hb31100, 24'hc22200,
    24'hd22200, 24'hb22200, 24'ha22200, 24'h922200, 24'h822200, 24'hb02200, 24'h722200,
    24'ha02200, 24'h001100, 24'ha51100};

  // free-running clock, 20 ns period
  always #10 mclk_in = ~mclk_in;

  cpu_instruction_timing_decoder i_dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in), .issue_valid_in(issue_valid_in),
    .issue_in(issue_in), .cond_in(cond_in), .acc_in(acc_in),
    .data_pointer_16_in(data_pointer_16_in), .ret_addr_in(ret_addr_in),
    .bank_select_field_in(bank_select_field_in), .ready_out(ready_out), .pc_out(pc_out),
    .len_out(len_out), .cycles_out(cycles_out), .taken_out(taken_out),
    .bit_clear_out(bit_clear_out), .bank_register_operand_out(bank_register_operand_out),
    .indirect_pointer_operand_out(indirect_pointer_operand_out),
    .direct_sfr_out(direct_sfr_out));

  code_memory_model i_mem (.pc_in(pc_out), .issue_out(issue_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check

  task automatic conclude;
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // waits for ready (enable toggling meanwhile), loads one instruction, notes its result
  task automatic run(input logic [23:0] ent, input logic c);
    logic [15:0] nx;
    logic [7:0]  o1;
    logic [7:0]  o2;
    exp_t        x;
    int          k;
    k = 0;
    while (ready_out !== 1'b1 && k < 100) begin
      @(negedge mclk_in);
      if (ready_out !== 1'b1) ce_in = 1'($random(seed));
      k++;
    end
    // a sequencer that never comes back ready is a failure, not a skip
    if (ready_out !== 1'b1) n_errors++;
    o1 = 8'($random(seed));
    o2 = 8'($random(seed));
    i_mem.mem[exp_pc] = ent[23:16];
    i_mem.mem[16'(exp_pc + 16'h1)] = o1;
    i_mem.mem[16'(exp_pc + 16'h2)] = o2;
    ce_in = 1'b1;
    issue_valid_in = 1'b1;
    cond_in = c;
    acc_in = 8'($random(seed));
    data_pointer_16_in = 16'($random(seed));
    ret_addr_in = 16'($random(seed));
    bank_select_field_in = 2'($random(seed));
    nx = exp_pc + 16'(ent[15:12]);
    x.len = ent[13:12];
    x.taken = (ent[7:4] != 4'h0) && (!ent[0] || c);
    x.cyc = ent[11:8] + 4'(ent[0] & c);
    case (ent[7:4])
      4'h1: x.pc = nx + {{8{o1[7]}}, o1};
      4'h2: x.pc = nx + {{8{o2[7]}}, o2};
      4'h3: x.pc = {nx[15:11], ent[23:21], o1};
      4'h4: x.pc = {o1, o2};
      4'h5: x.pc = ret_addr_in;
      4'h6: x.pc = 16'(acc_in) + data_pointer_16_in;
      default: x.pc = nx;
    endcase
    if (!x.taken) x.pc = nx;
    x.bclr = (ent[23:16] == 8'h10) && c;
    x.breg = {3'h0, bank_select_field_in, ent[18:16]};
    x.iptr = {3'h0, bank_select_field_in, 2'h0, ent[16]};
    x.sfr = o1[7];
    exp_pc = x.pc;
    q.push_back(x);
    @(negedge mclk_in);
    // while busy the strobe may stay up: such issues must be ignored
    if (ready_out !== 1'b1) issue_valid_in = 1'($random(seed));
  endtask : run

  // counts enabled edges between accepted issues
  always @(posedge mclk_in) begin
    if (ce_in) n_edges++;
    if (rstn_in && ce_in && issue_valid_in && ready_out) begin
      if (have_prev) check(16'(n_edges), 16'(prev_cyc));
      n_edges = 0;
      pend = 1'b1;
    end
  end

  // results appear the cycle after acceptance: compare with the oldest note
  always @(negedge mclk_in) begin
    if (pend) begin
      pend = 1'b0;
      e = q.pop_front();
      check(16'(len_out), 16'(e.len));
      check(16'(cycles_out), 16'(e.cyc));
      check(16'(taken_out), 16'(e.taken));
      check(pc_out, e.pc);
      check(16'(bit_clear_out), 16'(e.bclr));
      check(16'(bank_register_operand_out), 16'(e.breg));
      check(16'(indirect_pointer_operand_out), 16'(e.iptr));
      check(16'(direct_sfr_out), 16'(e.sfr));
      prev_cyc = e.cyc;
      have_prev = 1'b1;
    end
  end

  initial begin
    rstn_in = 1'b0;
    ce_in = 1'b1;
    issue_valid_in = 1'b0;
    cond_in = 1'b0;
    acc_in = 8'h00;
    data_pointer_16_in = 16'h0000;
    ret_addr_in = 16'h0000;
    bank_select_field_in = 2'h0;
    exp_pc = 16'h0000;
    have_prev = 1'b0;
    pend = 1'b0;
    // page jumps and calls sit in all eight high-bit positions
    for (int k = 0; k < 8; k++) begin
      tbl.push_back({3'(k), 5'h11, 16'h2330});
      tbl.push_back({3'(k), 5'h01, 16'h2330});
    end
    repeat (3) @(negedge mclk_in);
    rstn_in = 1'b1;
    foreach (tbl[i]) for (int c = 0; c < 2; c++) run(tbl[i], 1'(c));
    // reset in mid-run, once the last instruction has finished
    while (ready_out !== 1'b1) @(negedge mclk_in);
    rstn_in = 1'b0;
    issue_valid_in = 1'b0;
    have_prev = 1'b0;
    repeat (2) @(negedge mclk_in);
    check(pc_out, 16'h0000);
    check(16'({ready_out, len_out, cycles_out, taken_out}), 16'h00a2);
    rstn_in = 1'b1;
    exp_pc = 16'h0000;
    foreach (tbl[i]) run(tbl[i], 1'($random(seed)));
    // drop the strobe once ready returns, before the next edge, so no unnoted issue slips in
    while (ready_out !== 1'b1) @(negedge mclk_in);
    issue_valid_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    check(16'(q.size()), 16'h0000);
    conclude();
  end

  // watchdog: the run needs a few thousand cycles at most
  initial begin
    repeat (30000) @(posedge mclk_in);
    n_errors++;
    conclude();
  end
endmodule : tb_cpu_instruction_timing_decoder
